/* hdl/pffc_top.sv */
// Printer-side forms feed, emitter, paper out, ready and wire check logic.
// Assumes all inputs arrive as asynchronous pins from the attachment or sensors.
`include "pffc_map.svh"
`default_nettype none
module pffc_top #(
   parameter int unsigned WIRE_ON_US = `PFFC_WIRE_ON_US,
   parameter int unsigned WIRES      = 8
) (
   // Clock and reset
   input  wire logic               CLK,
   input  wire logic               RST_B,
   // Forms motor drive from the attachment {A, A_n, B, B_n}
   input  wire logic [3:0]         FORMS_DRIVE,
   // Print magnet drives and wire check clear
   input  wire logic [WIRES-1:0]   MAGNET_FIRE,
   input  wire logic               WIRE_CHECK_CLR,
   // Sensors
   input  wire logic               EOF_SWITCH,
   input  wire logic               RELEASE_FWD,
   input  wire logic               POWER_OK,
   input  wire logic               PICKUP_MARGIN,
   input  wire logic [2:0]         PICKUP_EMIT,
   // Outputs to the attachment
   output logic                    FORMS_EMIT_A,
   output logic                    FORMS_EMIT_B,
   output pffc_pkg::pffc_dir_t     FORMS_DIR,
   output logic                    PAPER_OUT_SENSE,
   output logic                    READY,
   output logic                    WIRE_CHECK,
   output logic                    LEFT_MARGIN,
   output logic [2:0]              PRINT_EMIT
);
   import pffc_pkg::*;

   localparam int unsigned SW     = WIRES + 12;
   localparam int unsigned LIMIT  = WIRE_ON_US * `PFFC_CLK_MHZ;
   localparam int unsigned CW     = $clog2(LIMIT + 1);

   // ----------------------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------------------
   logic [SW-1:0] meta_ff;
   logic [SW-1:0] sync_ff;
   logic [SW-1:0] nxt_meta;

   // Two flops on every pin before any logic reads it
   always_comb begin
      nxt_meta = {FORMS_DRIVE, MAGNET_FIRE, WIRE_CHECK_CLR, EOF_SWITCH, RELEASE_FWD,
                  POWER_OK, PICKUP_MARGIN, PICKUP_EMIT};
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= meta_ff;
      end
   end

   logic [3:0]       drv_s;
   logic [WIRES-1:0] fire_s;
   logic             clr_s;
   logic             eof_s;
   logic             lever_s;
   logic             pwr_s;
   logic             margin_s;
   logic [2:0]       emit_s;
   assign {drv_s, fire_s, clr_s, eof_s, lever_s, pwr_s, margin_s, emit_s} = sync_ff;

   // ----------------------------------------------------------------------------
   // Forms motor step tracking and emitter disk
   // ----------------------------------------------------------------------------
   logic [1:0] pat_idx;
   logic       pat_ok;
   logic [1:0] idx_ff;
   logic [1:0] nxt_idx;
   logic       have_ff;
   logic       nxt_have;
   logic [7:0] pos_ff;
   logic [7:0] nxt_pos;
   logic       step_fwd;
   logic       step_rev;
   logic       em_a_ff;
   logic       em_b_ff;
   logic       nxt_em_a;
   logic       nxt_em_b;
   pffc_dir_t  dir_ff;
   pffc_dir_t  nxt_dir;

   // Decode the drive pattern into a phase index
   always_comb begin
      pat_ok  = 1'b1;
      pat_idx = 2'h0;
      case (drv_s)
         `PFFC_PAT_0: pat_idx = 2'h0;
         `PFFC_PAT_1: pat_idx = 2'h1;
         `PFFC_PAT_2: pat_idx = 2'h2;
         `PFFC_PAT_3: pat_idx = 2'h3;
         default:     pat_ok  = 1'b0;
      endcase
   end

   // Each phase shift turns the disk 2 degrees; order gives direction
   always_comb begin
      step_fwd = pat_ok && have_ff && (pat_idx == idx_ff + 2'h1);
      step_rev = pat_ok && have_ff && (pat_idx == idx_ff - 2'h1);
      nxt_idx  = pat_ok ? pat_idx : idx_ff;
      nxt_have = have_ff | pat_ok;
      nxt_pos  = pos_ff;
      nxt_dir  = dir_ff;
      if (step_fwd) begin
         nxt_pos = (pos_ff == `PFFC_POS_LAST) ? `PFFC_POS_ZERO : pos_ff + 8'h01;  // RL1
         nxt_dir = PFFC_DIR_FWD;
      end else if (step_rev) begin
         nxt_pos = (pos_ff == `PFFC_POS_ZERO) ? `PFFC_POS_LAST : pos_ff - 8'h01;  // RL1
         nxt_dir = PFFC_DIR_REV;
      end
      // Outer track A leads inner track B by one 2 degree step
      nxt_em_a = (nxt_pos[1:0] == `PFFC_PH_A_RISE) || (nxt_pos[1:0] == `PFFC_PH_B_RISE);  // RL2
      nxt_em_b = (nxt_pos[1:0] == `PFFC_PH_B_RISE) || (nxt_pos[1:0] == `PFFC_PH_B_HIGH);  // RL2
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         idx_ff  <= 2'h0;
         have_ff <= 1'b0;
         pos_ff  <= `PFFC_POS_ZERO;
         dir_ff  <= PFFC_DIR_HOLD;
         em_a_ff <= 1'b0;
         em_b_ff <= 1'b0;
      end else begin
         idx_ff  <= nxt_idx;
         have_ff <= nxt_have;
         pos_ff  <= nxt_pos;
         dir_ff  <= nxt_dir;
         em_a_ff <= nxt_em_a;
         em_b_ff <= nxt_em_b;
      end
   end

   // ----------------------------------------------------------------------------
   // Wire check latch, ready, paper out and print emitter pass-through
   // ----------------------------------------------------------------------------
   logic [WIRES-1:0] over;
   logic             wc_ff;
   logic             nxt_wc;
   logic             rdy_ff;
   logic             nxt_rdy;
   logic             po_ff;
   logic             nxt_po;
   logic             lm_ff;
   logic [2:0]       pe_ff;

   // One on-time watchdog per print magnet driver
   for (genvar i = 0; i < WIRES; i++) begin : g_guard
      pffc_wire_guard #(.LIMIT(LIMIT), .CW(CW)) u_guard (
         .clk   (CLK),
         .rst_b (RST_B),
         .drive (fire_s[i]),
         .over  (over[i])
      );
   end

   // Set beats clear so an overrun in the clear cycle is kept
   always_comb begin
      nxt_wc  = (|over) ? 1'b1 : (clr_s ? 1'b0 : wc_ff);  // RL13 RL14
      nxt_rdy = pwr_s && !nxt_wc;                          // RL12
      nxt_po  = eof_s && lever_s;                          // RL5
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         wc_ff  <= 1'b0;
         rdy_ff <= 1'b0;
         po_ff  <= 1'b0;
         lm_ff  <= 1'b0;
         pe_ff  <= 3'h0;
      end else begin
         wc_ff  <= nxt_wc;
         rdy_ff <= nxt_rdy;
         po_ff  <= nxt_po;
         lm_ff  <= margin_s;  // RL15
         pe_ff  <= emit_s;    // RL15
      end
   end

   assign FORMS_EMIT_A    = em_a_ff;
   assign FORMS_EMIT_B    = em_b_ff;
   assign FORMS_DIR       = dir_ff;
   assign PAPER_OUT_SENSE = po_ff;
   assign READY           = rdy_ff;
   assign WIRE_CHECK      = wc_ff;
   assign LEFT_MARGIN     = lm_ff;
   assign PRINT_EMIT      = pe_ff;

   // ----------------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------------
   sequence s_fwd_step;
      step_fwd && (pos_ff != `PFFC_POS_LAST);
   endsequence
   sequence s_pos_up;
      pos_ff == $past(pos_ff) + 8'h01;
   endsequence

   AST_STEP_FWD: assert property (@(posedge CLK) disable iff (!RST_B)  // RL1
      s_fwd_step |=> s_pos_up) else $error("Forward step did not advance position by one");
   AST_STEP_WRAP: assert property (@(posedge CLK) disable iff (!RST_B)  // RL2
      step_rev && pos_ff == `PFFC_POS_ZERO |=> pos_ff == `PFFC_POS_LAST)
      else $error("Reverse step from zero did not wrap to last slot position");
   AST_NO_STEP: assert property (@(posedge CLK) disable iff (!RST_B)  // RL1
      !step_fwd && !step_rev |=> $stable(pos_ff) && $stable(FORMS_EMIT_A) && $stable(FORMS_EMIT_B))
      else $error("Emitter moved without a motor step");
   AST_ALTERNATE: assert property (@(posedge CLK) disable iff (!RST_B)  // RL1
      !($changed(FORMS_EMIT_A) && $changed(FORMS_EMIT_B)))
      else $error("Both emitter channels changed on one step");
   AST_A_LEADS: assert property (@(posedge CLK) disable iff (!RST_B)  // RL2
      step_fwd && !FORMS_EMIT_A && !FORMS_EMIT_B |=> FORMS_EMIT_A && !FORMS_EMIT_B)
      else $error("Channel A did not lead channel B");
   AST_PAPER_OUT: assert property (@(posedge CLK) disable iff (!RST_B)  // RL5
      !lever_s |=> !PAPER_OUT_SENSE)
      else $error("Paper out shown with release lever back");
   AST_PAPER_SET: assert property (@(posedge CLK) disable iff (!RST_B)  // RL5
      eof_s && lever_s |=> PAPER_OUT_SENSE) else $error("Paper out not shown");
   AST_WC_SET: assert property (@(posedge CLK) disable iff (!RST_B)  // RL13
      |over |=> WIRE_CHECK && !READY) else $error("Overrun did not latch wire check and drop ready");
   AST_WC_HOLD: assert property (@(posedge CLK) disable iff (!RST_B)  // RL14
      WIRE_CHECK && !clr_s |=> WIRE_CHECK) else $error("Wire check dropped without clear");
   AST_READY: assert property (@(posedge CLK) disable iff (!RST_B)  // RL12
      pwr_s && !WIRE_CHECK && !(|over) && !clr_s |=> READY) else $error("Ready not shown while able");
   AST_EMIT_PASS: assert property (@(posedge CLK) disable iff (!RST_B)  // RL15
      1'b1 |=> PRINT_EMIT == $past(emit_s) && LEFT_MARGIN == $past(margin_s))
      else $error("Print emitter or margin not passed through");
endmodule
`default_nettype wire

/* hdl/pffc_map.svh */
// Constants for the printer forms feed control block.
// Assumes a single 125 MHz clock; included by bare name from the design files.
//
// Behaviour
// RL1: Emit one forms emitter pulse per 2 degree motor step, alternating channels.
// RL2: Two 45-slot channels, outer leads inner by 2 degrees, outputs phase offset.
// RL3: Attachment counts 16 emitter pulses as one 1/6 inch line.
// RL4: Attachment closes the loop: emitter A drives A phases, emitter B drives B phases. The model shifts phases on bench step commands instead.
// RL5: Paper out asserted near form end, only with release lever forward.
// RL6: Attachment ignores paper out in single form mode, honours it in continuous.
// RL7: Cut form reset key sets attachment line counter to 1.
// RL8: Cut form line key never spaces past forms length minus 3.
// RL9: Cut form print stops when line equals forms length minus 3.
// RL10: Cut form mode ignores the page key.
// RL11: Finished cut form is skipped to last line, head returns left.
// RL12: Printer presents ready whenever it can accept operations.
// RL13: Printer latches wire check when any magnet driver stays on too long.
// RL14: Attachment clears wire check by a dedicated signal; latch holds until then.
// RL15: Printer supplies left margin and three print emitter phase signals.
// RL16: Attachment shifts stepper phases one at a time, 2 degrees each.
// RL17: Attachment ORs the three print emitter phases for 0.010 inch pulses.
// RL18: Attachment counts lines per 16 pulses against a forms length register.
`ifndef PFFC_MAP_SVH
`define PFFC_MAP_SVH

// ----------------------------------------------------------------------------
// Emitter disk geometry
// ----------------------------------------------------------------------------
`define PFFC_STEP_DEG     2
`define PFFC_SLOTS        45
`define PFFC_POS_COUNT    8'd180
`define PFFC_POS_LAST     8'd179
`define PFFC_POS_ZERO     8'd0
`define PFFC_PH_A_RISE    2'h1
`define PFFC_PH_B_RISE    2'h2
`define PFFC_PH_B_HIGH    2'h3

// ----------------------------------------------------------------------------
// Stepper drive patterns {A, A_n, B, B_n}
// ----------------------------------------------------------------------------
`define PFFC_PAT_0        4'ha
`define PFFC_PAT_1        4'h6
`define PFFC_PAT_2        4'h5
`define PFFC_PAT_3        4'h9

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PFFC_CLK_MHZ      125
`define PFFC_WIRE_ON_US   1000

`endif

/* hdl/pffc_pkg.sv */
// Types for the printer forms feed control block.
// Assumes pffc_map.svh holds the numeric constants.
`default_nettype none
package pffc_pkg;
   // Direction of the most recent forms motor step
   typedef enum logic [1:0] {PFFC_DIR_HOLD, PFFC_DIR_FWD, PFFC_DIR_REV} pffc_dir_t;
endpackage
`default_nettype wire

/* hdl/pffc_wire_guard.sv */
// On-time watchdog for one print magnet driver.
// Assumes the drive input is already synchronised to clk.
`default_nettype none
module pffc_wire_guard #(
   parameter int unsigned LIMIT = 125000,
   parameter int unsigned CW    = 18
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // Driver level and overrun flag
   input  wire logic drive,
   output logic      over
);
   logic [CW-1:0] cnt_ff;
   logic [CW-1:0] nxt_cnt;
   logic          over_ff;
   logic          nxt_over;

   // Count cycles while the driver is on; flag once the limit is reached
   always_comb begin
      nxt_cnt  = cnt_ff;
      nxt_over = 1'b0;
      if (!drive) begin
         nxt_cnt = '0;
      end else if (cnt_ff >= CW'(LIMIT - 1)) begin
         nxt_over = 1'b1;
      end else begin
         nxt_cnt = cnt_ff + CW'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff  <= '0;
         over_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         over_ff <= nxt_over;
      end
   end

   assign over = over_ff;
endmodule
`default_nettype wire

/* bench/pffc_attach.sv */
// Attachment-side partner: shifts the forms motor phases and counts lines.
// Assumes the bench clock and reset; bench commands arrive on posedge.
`include "pffc_map.svh"
`default_nettype none
module pffc_attach (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rst_b,
   // Bench commands
   input  wire logic                step,
   input  wire logic                fwd,
   input  wire logic [3:0]          bad,
   input  wire logic                clr,
   input  wire logic                line_rst,
   // Operator setup: continuous forms mode and programmed forms length
   input  wire logic                cont,
   input  wire logic [7:0]          form_len,
   // Printer side
   input  wire logic                emit_a,
   input  wire logic                emit_b,
   input  wire pffc_pkg::pffc_dir_t dir,
   input  wire logic                paper_out,
   input  wire logic                margin,
   input  wire logic [2:0]          pr_emit,
   output logic [3:0]               drive,
   output logic                     clr_pin,
   output logic [7:0]               lines,
   // Attachment decisions
   output logic                     forms_out,
   output logic                     head_pulse,
   output logic                     space_ok,
   output logic                     print_ok,
   output logic                     page_ok,
   output logic [7:0]               eject_to,
   output logic                     home_req
);
   timeunit 1ns;
   timeprecision 1ps;
   import pffc_pkg::*;
   logic [1:0] ph_ff;
   logic [3:0] cnt_ff;
   logic [1:0] ab_ff;
   logic [7:0] limit;
   // One phase shift per command; order sets direction
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ph_ff <= 2'h0;
      end else if (step) begin
         ph_ff <= fwd ? ph_ff + 2'h1 : ph_ff - 2'h1;
      end
   end
   // Phase pattern, or a commanded bad pattern
   always_comb begin
      case (ph_ff)
         2'h0: drive = `PFFC_PAT_0;
         2'h1: drive = `PFFC_PAT_1;
         2'h2: drive = `PFFC_PAT_2;
         default: drive = `PFFC_PAT_3;
      endcase
      if (bad != 4'h0) drive = bad;
   end
   // Sixteen forward pulses make one line
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff <= 4'h0;
         lines  <= 8'h0;
         ab_ff  <= 2'h0;
      end else begin
         ab_ff <= {emit_a, emit_b};
         if (line_rst) begin
            cnt_ff <= 4'h0;
            lines  <= 8'h1;
         end else if ({emit_a, emit_b} != ab_ff && dir == PFFC_DIR_FWD) begin
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff == 4'hf) lines <= lines + 8'h1;
         end
      end
   end
   // Dedicated wire check clear line
   assign clr_pin = clr;
   // Cut form limits, paper out qualification and head position pulse
   always_comb begin
      limit      = form_len - 8'h03;
      forms_out  = cont && paper_out;
      head_pulse = |pr_emit;
      space_ok   = cont || (lines < limit);
      print_ok   = cont || (lines != limit);
      page_ok    = cont;
      eject_to   = cont ? lines : form_len;
      home_req   = !cont && (lines == form_len) && !margin;
   end
endmodule
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the printer forms feed control block.
// Assumes pffc_top with a 1 us wire limit and the attachment model.
`include "pffc_map.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import pffc_pkg::*;
   // ----------------------------
   // Stimulus and observed nets
   // ----------------------------
   logic CLK = 1'b0, RST_B = 1'b0, POWER_OK = 1'b0, EOF_SWITCH = 1'b0;
   logic RELEASE_FWD = 1'b0, PICKUP_MARGIN = 1'b0, WIRE_CHECK_CLR;
   logic [2:0] PICKUP_EMIT = 3'h0, PRINT_EMIT;
   logic [7:0] MAGNET_FIRE = 8'h0, lines;
   logic [3:0] FORMS_DRIVE, bad = 4'h0;
   logic FORMS_EMIT_A, FORMS_EMIT_B, PAPER_OUT_SENSE, READY, WIRE_CHECK, LEFT_MARGIN;
   pffc_dir_t FORMS_DIR;
   logic step = 1'b0, fwd = 1'b0, clr = 1'b0, line_rst = 1'b0;
   logic cont = 1'b0, forms_out, head_pulse, space_ok, print_ok, page_ok, home_req;
   logic [7:0] form_len = 8'h06, eject_to;
   logic [3:0] exp_q [$];
   logic [3:0] pat [4] = '{`PFFC_PAT_0, `PFFC_PAT_1, `PFFC_PAT_2, `PFFC_PAT_3};
   int n_fail = 0, cmp_count = 0, pos = 0, i, n;
   // Clock
   always #4 CLK = ~CLK;
   pffc_top #(.WIRE_ON_US(1), .WIRES(8)) dut_u (.CLK(CLK), .RST_B(RST_B),
      .FORMS_DRIVE(FORMS_DRIVE), .MAGNET_FIRE(MAGNET_FIRE), .WIRE_CHECK_CLR(WIRE_CHECK_CLR),
      .EOF_SWITCH(EOF_SWITCH), .RELEASE_FWD(RELEASE_FWD), .POWER_OK(POWER_OK),
      .PICKUP_MARGIN(PICKUP_MARGIN), .PICKUP_EMIT(PICKUP_EMIT), .FORMS_EMIT_A(FORMS_EMIT_A),
      .FORMS_EMIT_B(FORMS_EMIT_B), .FORMS_DIR(FORMS_DIR), .PAPER_OUT_SENSE(PAPER_OUT_SENSE),
      .READY(READY), .WIRE_CHECK(WIRE_CHECK), .LEFT_MARGIN(LEFT_MARGIN), .PRINT_EMIT(PRINT_EMIT));
   pffc_attach attach_u (.clk(CLK), .rst_b(RST_B), .step(step), .fwd(fwd), .bad(bad),
      .clr(clr), .line_rst(line_rst), .cont(cont), .form_len(form_len), .emit_a(FORMS_EMIT_A),
      .emit_b(FORMS_EMIT_B), .dir(FORMS_DIR), .paper_out(PAPER_OUT_SENSE), .margin(LEFT_MARGIN),
      .pr_emit(PRINT_EMIT), .drive(FORMS_DRIVE), .clr_pin(WIRE_CHECK_CLR), .lines(lines),
      .forms_out(forms_out), .head_pulse(head_pulse), .space_ok(space_ok), .print_ok(print_ok),
      .page_ok(page_ok), .eject_to(eject_to), .home_req(home_req));
   // ----------------------------
   // Checking helpers
   // ----------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      cmp_count++;
      if (seen !== want) begin
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, want);
         n_fail++;
      end
   endtask
   task automatic wrap_up;
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Emitter levels for a position modulo four
   function automatic logic [1:0] em(input int p);
      case (p)
         0: return 2'h0;
         1: return 2'h2;
         2: return 2'h3;
         default: return 2'h1;
      endcase
   endfunction
   // One motor step: note the expected emitter state, then let it land
   task automatic mstep(input logic f);
      step <= 1'b1;
      fwd  <= f;
      pos = (pos + (f ? 1 : 3)) % 4;
      exp_q.push_back({f ? PFFC_DIR_FWD : PFFC_DIR_REV, em(pos)});
      @(posedge CLK);
      step <= 1'b0;
      repeat ($urandom_range(3, 1)) @(posedge CLK);
   endtask
   // Commanded bad pattern that must be ignored
   task automatic junk(input logic [3:0] v);
      bad <= v;
      repeat (5) @(posedge CLK);
   endtask
   // Bounded waits; running out counts as a failure
   task automatic drain;
      for (n = 0; n < 40 && exp_q.size() != 0; n++) @(posedge CLK);
      if (exp_q.size() != 0) begin
         n_fail++;
         wrap_up();
      end
   endtask
   task automatic wait_wc;
      for (n = 0; n < 200 && WIRE_CHECK !== 1'b1; n++) @(posedge CLK);
      if (WIRE_CHECK !== 1'b1) begin
         n_fail++;
         wrap_up();
      end
   endtask
   // Emitter watcher: every change takes the oldest note
   always @(FORMS_EMIT_A or FORMS_EMIT_B) begin
      if (RST_B === 1'b1) begin
         #1;
         if (exp_q.size() == 0) chk(8'h01, 8'h00);
         else chk({4'h0, FORMS_DIR, FORMS_EMIT_A, FORMS_EMIT_B}, {4'h0, exp_q.pop_front()});
      end
   end
   // ----------------------------
   // Main sequence
   // ----------------------------
   initial begin
      void'($urandom(98687));
      repeat (16) @(posedge CLK);
      RST_B <= 1'b1;
      repeat (4) @(posedge CLK);
      chk(READY, 8'h0);
      POWER_OK <= 1'b1;
      repeat (4) @(posedge CLK);
      chk(READY, 8'h1);
      for (i = 0; i < 200; i++) mstep(i < 4 ? 1'b0 : 1'($urandom_range(1, 0)));
      drain();
      junk(4'hf);
      junk(pat[(pos + 2) % 4]);
      junk(4'h0);
      line_rst <= 1'b1;
      @(posedge CLK);
      line_rst <= 1'b0;
      for (i = 0; i < 32; i++) mstep(1'b1);
      drain();
      repeat (3) @(posedge CLK);
      chk(lines, 8'h3);
      // Line 3 of a six-line cut form sits at the limit; continuous mode lifts it
      for (i = 0; i < 2; i++) begin
         cont <= 1'(i);
         repeat (2) @(posedge CLK);
         chk(space_ok, 8'(i));
         chk(print_ok, 8'(i));
         chk(page_ok, 8'(i));
         chk(eject_to, (i == 1) ? 8'h03 : 8'h06);
      end
      // Cut form finished on its last line with the head away from the margin
      form_len <= 8'h03;
      cont <= 1'b0;
      repeat (2) @(posedge CLK);
      chk(home_req, 8'h1);
      for (i = 0; i < 8; i++) begin
         {cont, EOF_SWITCH, RELEASE_FWD} <= 3'(i);
         repeat (4) @(posedge CLK);
         chk(PAPER_OUT_SENSE, 8'(i % 4 == 3));
         chk(forms_out, 8'(i == 7));
      end
      for (i = 0; i < 8; i++) begin
         {PICKUP_MARGIN, PICKUP_EMIT} <= 4'($urandom);
         repeat (4) @(posedge CLK);
         chk({LEFT_MARGIN, PRINT_EMIT}, {PICKUP_MARGIN, PICKUP_EMIT});
         chk(head_pulse, 8'(|PICKUP_EMIT));
      end
      for (i = 0; i < 8; i++) begin
         MAGNET_FIRE <= 8'h1 << i;
         wait_wc();
         chk(8'(n >= 120), 8'h1);
         @(posedge CLK);
         chk(READY, 8'h0);
         MAGNET_FIRE <= 8'h0;
         repeat (10) @(posedge CLK);
         chk(WIRE_CHECK, 8'h1);
         clr <= 1'b1;
         repeat (5) @(posedge CLK);
         clr <= 1'b0;
         repeat (2) @(posedge CLK);
         chk({READY, WIRE_CHECK}, 8'h2);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
